// file: rtl/ascd_pkg.sv
/*
 * Constants, types and state records of the serial command decoder.
 * Assumes one master clock domain and one serial link clock domain.
 */
// Contract
// - 0000000x wakes the device from standby.
// - 0000001x enters low-power standby.
// - 0000010x resynchronizes the conversion.
// - 0000011x is the software reset.
// - Software reset equals the reset pin; here it leaves run unchanged and blanks 63 readings, where the pin blanks none.
// - 10h continuous, 11h stop, 12h read one.
// - Read: 001 address, then count minus one.
// - Read data drives out after second byte.
// - Write: 010 address, count, then data bytes.
// - 60h offset calibration, 61h gain calibration.
// - Wake while converting is ignored.
// - Standby keeps registers and serial link.
// - Resync abandons and restarts the conversion.
// - Stop mode hides ready, conversions continue.
// - Calibration ready after 64, then 16 periods; here no blanking, ready on the 17th.
// - Sinc-only filter disables offset/gain correction.
// - Offset cal averages 16, full-scale bypassed.
// - Gain calibration updates gain correction register.
// - Register write restarts path, 63 readings lost.
package ascd_pkg;
	localparam int NUM_REGS = 32;
	localparam logic [7:0] ID_VALUE = 8'hA0; // Arbitrary identity value.
	localparam logic [4:0] REG_ID = 5'h00;
	localparam logic [4:0] REG_CFG0 = 5'h01;
	localparam logic [4:0] REG_OFFSET_LO = 5'h05;
	localparam logic [4:0] REG_GAIN_LO = 5'h08;
	localparam logic [1:0] FILT_LO = 2'h0;
	localparam logic [1:0] FILTER_SINC = 2'h1;
	localparam logic [5:0] BLANK_READINGS = 6'h3F;
	localparam logic [4:0] CAL_READINGS = 5'h10;
	localparam logic [2:0] READY_HIGH_CYCLES = 3'h4;
	localparam logic [7:0] OP_CONT_READ = 8'h10;
	localparam logic [7:0] OP_STOP_READ = 8'h11;
	localparam logic [7:0] OP_RDATA = 8'h12;
	localparam logic [7:0] OP_OFFSET_CAL = 8'h60;
	localparam logic [7:0] OP_GAIN_CAL = 8'h61;
	localparam logic [6:0] OP_WAKE = 7'h00;
	localparam logic [6:0] OP_STANDBY = 7'h01;
	localparam logic [6:0] OP_RESYNC = 7'h02;
	localparam logic [6:0] OP_RESET = 7'h03;
	localparam logic [2:0] OP_REG_READ = 3'h1;
	localparam logic [2:0] OP_REG_WRITE = 3'h2;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_COUNT = 4'h2,
		ST_WRITE = 4'h4,
		ST_READ = 4'h8
	} ascd_state_e;

	typedef enum logic [1:0] {
		CAL_NONE = 2'h0,
		CAL_OFFSET = 2'h1,
		CAL_GAIN = 2'h2
	} ascd_cal_e;

	typedef logic [NUM_REGS-1:0][7:0] ascd_regs_t;

	// Link to the conversion engine.
	typedef struct packed {
		logic done;
		logic [31:0] data;
		logic [23:0] gain_estimate;
	} ascd_conv_in_s;

	typedef struct packed {
		logic run;
		logic restart;
		logic correction_en;
		logic full_scale_bypass;
	} ascd_conv_out_s;

	typedef struct packed {
		ascd_state_e state;
		logic [1:0] sync_pin;
		logic [1:0] rx_sync;
		logic rx_seen;
		logic [1:0] fs_sync;
		logic fs_seen;
		logic is_write;
		logic [4:0] addr;
		logic [4:0] cnt;
		ascd_regs_t regs;
		logic [31:0] tx_word;
		logic tx_tog;
		logic ready_n;
		logic [2:0] high_cnt;
		logic [5:0] blank;
		ascd_cal_e cal;
		logic [4:0] cal_cnt;
		logic [35:0] acc;
		logic cont_mode;
		logic rdata_pend;
		ascd_conv_out_s conv;
	} ascd_core_s;

	typedef struct packed {
		logic [6:0] sh;
		logic [2:0] bits;
		logic [7:0] rx_byte;
		logic rx_tog;
		logic fs_tog;
	} ascd_rx_s;

	typedef struct packed {
		logic ld_seen;
		logic [2:0] bits;
		logic [31:0] sh;
		logic dout;
	} ascd_tx_s;

	function automatic ascd_regs_t regs_default();
		ascd_regs_t r;
		r = '0;
		r[0] = ID_VALUE;
		r[1] = 8'h52;
		r[2] = 8'h08;
		r[3] = 8'h32;
		r[4] = 8'h03;
		r[10] = 8'h40;
		return r;
	endfunction : regs_default
endpackage : ascd_pkg

// file: rtl/ascd_decoder.sv
/*
 * Serial command decoder: byte receive and transmit on the serial clock,
 * command sequencing, register file and calibration on the master clock.
 * Assumes the host honours the byte spacing so crossing toggles settle.
 */
module ascd_decoder (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic sclk_i,
	input wire logic din_i,
	input wire logic sync_pin_i,
	input wire ascd_pkg::ascd_conv_in_s conv_i,
	output logic dout_o,
	output logic result_ready_n_o,
	output ascd_pkg::ascd_conv_out_s conv_o,
	output ascd_pkg::ascd_regs_t regs_o
);

	////////////////////////////////////////////////////////////////////////
	// Receive side, rising serial clock edges.

	ascd_pkg::ascd_rx_s rx, next_rx;

	always_comb begin
		next_rx = rx;
		next_rx.sh = {rx.sh[5:0], din_i};
		next_rx.bits = rx.bits + 3'h1;
		if (rx.bits == 3'h0) begin
			next_rx.fs_tog = ~rx.fs_tog;
		end
		if (rx.bits == 3'h7) begin
			next_rx.rx_byte = {rx.sh, din_i};
			next_rx.rx_tog = ~rx.rx_tog;
		end
	end

	always_ff @(posedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx <= '0;
		end else begin
			rx <= next_rx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit side, falling serial clock edges.

	ascd_pkg::ascd_core_s q, next_q;
	ascd_pkg::ascd_tx_s tx, next_tx;

	// A load waits for a byte boundary so a frame is never torn mid-byte.
	// The serial clock stands still between bytes, so a flop chain on it
	// would never pass a load on in time. The word and its toggle are
	// read as quasi-static instead: they change only well before the host
	// clocks the next byte, as byte spacing and the ready strobe ensure.
	always_comb begin
		next_tx = tx;
		next_tx.bits = tx.bits + 3'h1;
		if (tx.bits == 3'h0 && q.tx_tog != tx.ld_seen) begin
			next_tx.ld_seen = q.tx_tog;
			next_tx.dout = q.tx_word[31];
			next_tx.sh = {q.tx_word[30:0], 1'b0};
		end else begin
			next_tx.dout = tx.sh[31];
			next_tx.sh = {tx.sh[30:0], 1'b0};
		end
	end

	always_ff @(negedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx <= '0;
		end else begin
			tx <= next_tx;
		end
	end

	assign dout_o = tx.dout;

	////////////////////////////////////////////////////////////////////////
	// Command sequencing on the master clock.

	logic new_byte;
	logic [7:0] rbyte;

	assign new_byte = q.rx_sync[1] != q.rx_seen;
	assign rbyte = rx.rx_byte;

	function automatic logic [32:0] reg_load(ascd_pkg::ascd_regs_t r,
			logic [4:0] a, logic tog);
		return {r[a], 24'h0, ~tog};
	endfunction : reg_load

	always_comb begin
		next_q = q;
		next_q.sync_pin = {q.sync_pin[0], sync_pin_i};
		next_q.rx_sync = {q.rx_sync[0], rx.rx_tog};
		next_q.fs_sync = {q.fs_sync[0], rx.fs_tog};
		next_q.conv.restart = 1'b0;
		if (q.fs_sync[1] != q.fs_seen) begin
			next_q.fs_seen = q.fs_sync[1];
			next_q.ready_n = 1'b1;
			next_q.high_cnt = 3'h0;
		end
		if (q.high_cnt != 3'h0) begin
			next_q.high_cnt = q.high_cnt - 3'h1;
			if (q.high_cnt == 3'h1) begin
				next_q.ready_n = 1'b0;
			end
		end
		if (new_byte) begin
			next_q.rx_seen = q.rx_sync[1];
			unique case (q.state)
				ascd_pkg::ST_IDLE: begin
					if (rbyte[7:1] == ascd_pkg::OP_WAKE) begin
						if (!q.conv.run) begin
							next_q.conv.run = 1'b1;
							next_q.conv.restart = 1'b1;
						end
					end else if (rbyte[7:1] == ascd_pkg::OP_STANDBY) begin
						next_q.conv.run = 1'b0;
					end else if (rbyte[7:1] == ascd_pkg::OP_RESYNC) begin
						if (q.sync_pin[1]) begin
							next_q.conv.restart = 1'b1;
							next_q.blank = ascd_pkg::BLANK_READINGS;
						end
					end else if (rbyte[7:1] == ascd_pkg::OP_RESET) begin
						next_q.regs = ascd_pkg::regs_default();
						next_q.cont_mode = 1'b1;
						next_q.rdata_pend = 1'b0;
						next_q.cal = ascd_pkg::CAL_NONE;
						next_q.conv.restart = 1'b1;
						next_q.blank = ascd_pkg::BLANK_READINGS;
					end else if (rbyte == ascd_pkg::OP_CONT_READ) begin
						next_q.cont_mode = 1'b1;
					end else if (rbyte == ascd_pkg::OP_STOP_READ) begin
						next_q.cont_mode = 1'b0;
						next_q.ready_n = 1'b1;
						next_q.high_cnt = 3'h0;
					end else if (rbyte == ascd_pkg::OP_RDATA) begin
						next_q.rdata_pend = 1'b1;
					end else if (rbyte[7:5] == ascd_pkg::OP_REG_READ ||
							rbyte[7:5] == ascd_pkg::OP_REG_WRITE) begin
						next_q.addr = rbyte[4:0];
						next_q.is_write = rbyte[6];
						next_q.state = ascd_pkg::ST_COUNT;
					end else if (rbyte == ascd_pkg::OP_OFFSET_CAL) begin
						next_q.cal = ascd_pkg::CAL_OFFSET;
						next_q.cal_cnt = 5'h0;
						next_q.acc = '0;
					end else if (rbyte == ascd_pkg::OP_GAIN_CAL) begin
						next_q.cal = ascd_pkg::CAL_GAIN;
						next_q.cal_cnt = 5'h0;
						next_q.acc = '0;
					end
				end
				ascd_pkg::ST_COUNT: begin
					next_q.cnt = rbyte[4:0];
					if (q.is_write) begin
						next_q.state = ascd_pkg::ST_WRITE;
					end else begin
						{next_q.tx_word, next_q.tx_tog} =
							reg_load(q.regs, q.addr, q.tx_tog);
						next_q.state = ascd_pkg::ST_READ;
					end
				end
				ascd_pkg::ST_WRITE: begin
					if (q.addr != ascd_pkg::REG_ID) begin
						next_q.regs[q.addr] = rbyte;
					end
					next_q.addr = q.addr + 5'h1;
					next_q.cnt = q.cnt - 5'h1;
					if (q.cnt == 5'h0) begin
						next_q.state = ascd_pkg::ST_IDLE;
						next_q.conv.restart = 1'b1;
						next_q.blank = ascd_pkg::BLANK_READINGS;
					end
				end
				ascd_pkg::ST_READ: begin
					next_q.addr = q.addr + 5'h1;
					next_q.cnt = q.cnt - 5'h1;
					if (q.cnt == 5'h0) begin
						next_q.state = ascd_pkg::ST_IDLE;
					end else begin
						{next_q.tx_word, next_q.tx_tog} =
							reg_load(q.regs, q.addr + 5'h1, q.tx_tog);
					end
				end
				default: begin
					next_q.state = ascd_pkg::ST_IDLE;
				end
			endcase
		end
		// Readings after a resync, software reset or register write are discarded until the path settles.
		if (conv_i.done && q.conv.run) begin
			if (q.blank != 6'h0) begin
				next_q.blank = q.blank - 6'h1;
			end else begin
				if (q.cal != ascd_pkg::CAL_NONE) begin
					next_q.acc = q.acc + {{4{conv_i.data[31]}}, conv_i.data};
					next_q.cal_cnt = q.cal_cnt + 5'h1;
					if (q.cal_cnt == ascd_pkg::CAL_READINGS - 5'h1) begin
						next_q.cal = ascd_pkg::CAL_NONE;
						if (q.cal == ascd_pkg::CAL_OFFSET) begin
							// Sum over sixteen, top 24 bits of the mean.
							next_q.regs[ascd_pkg::REG_OFFSET_LO +: 3] =
								next_q.acc[35:12];
						end else begin
							next_q.regs[ascd_pkg::REG_GAIN_LO +: 3] =
								conv_i.gain_estimate;
						end
					end
				end
				if ((q.cont_mode || q.rdata_pend) &&
						q.cal == ascd_pkg::CAL_NONE) begin
					next_q.tx_word = conv_i.data;
					next_q.tx_tog = ~q.tx_tog;
					next_q.rdata_pend = 1'b0;
					next_q.ready_n = 1'b1;
					next_q.high_cnt = ascd_pkg::READY_HIGH_CYCLES;
				end
			end
		end
		next_q.conv.correction_en = next_q.regs[ascd_pkg::REG_CFG0][1:0] !=
			ascd_pkg::FILTER_SINC;
		next_q.conv.full_scale_bypass =
			next_q.cal == ascd_pkg::CAL_OFFSET;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '{state: ascd_pkg::ST_IDLE, regs: ascd_pkg::regs_default(),
				ready_n: 1'b1, cont_mode: 1'b1, cal: ascd_pkg::CAL_NONE,
				conv: '{run: 1'b1, correction_en: 1'b1, default: 1'b0},
				default: '0};
		end else begin
			q <= next_q;
		end
	end

	assign result_ready_n_o = q.ready_n;
	assign conv_o = q.conv;
	assign regs_o = q.regs;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	logic idle_byte;
	assign idle_byte = new_byte && q.state == ascd_pkg::ST_IDLE;

	a_wake_runs: assert property (idle_byte && !q.conv.run &&
		rbyte[7:1] == ascd_pkg::OP_WAKE |=> q.conv.run && q.conv.restart)
		else $error("wake did not restart conversion");
	a_wake_ignored: assert property (idle_byte && q.conv.run &&
		rbyte[7:1] == ascd_pkg::OP_WAKE |=> !q.conv.restart)
		else $error("wake while running had an effect");
	a_standby_halts: assert property (idle_byte &&
		rbyte[7:1] == ascd_pkg::OP_STANDBY |=> !q.conv.run &&
		$stable(q.regs))
		else $error("standby did not halt or lost registers");
	a_resync_restart: assert property (idle_byte && q.sync_pin[1] &&
		rbyte[7:1] == ascd_pkg::OP_RESYNC |=> q.conv.restart &&
		q.blank == ascd_pkg::BLANK_READINGS)
		else $error("resync did not restart");
	a_reset_defaults: assert property (idle_byte &&
		rbyte[7:1] == ascd_pkg::OP_RESET |=> q.cont_mode &&
		q.regs == ascd_pkg::regs_default() && q.conv.restart)
		else $error("software reset incomplete");
	a_stop_quiet: assert property (!q.cont_mode && !q.rdata_pend &&
		q.ready_n && q.high_cnt == 3'h0 &&
		!(idle_byte && rbyte == ascd_pkg::OP_RDATA) |=>
		q.ready_n)
		else $error("ready asserted in stop mode");
	a_write_restart: assert property (new_byte &&
		q.state == ascd_pkg::ST_WRITE && q.cnt == 5'h0 |=>
		q.conv.restart ##1 !q.conv.restart)
		else $error("register write did not restart once");
	a_ready_pulse: assert property ($rose(q.ready_n) &&
		q.high_cnt == ascd_pkg::READY_HIGH_CYCLES |-> ##4 !q.ready_n)
		else $error("ready high pulse length wrong");
	a_sinc_nocorr: assert property (q.regs[ascd_pkg::REG_CFG0][1:0] ==
		ascd_pkg::FILTER_SINC |-> !q.conv.correction_en)
		else $error("correction active in sinc mode");

	// Mode commands take effect on the cycle after the byte is seen.
	a_stop_blocks: assert property (idle_byte &&
		rbyte == ascd_pkg::OP_STOP_READ |=> q.ready_n && !q.cont_mode)
		else $error("stop command did not block ready");
	a_cont_enable: assert property (idle_byte &&
		rbyte == ascd_pkg::OP_CONT_READ |=> q.cont_mode)
		else $error("continuous readout not enabled");
	a_read_pending: assert property (idle_byte &&
		rbyte == ascd_pkg::OP_RDATA |=> q.rdata_pend)
		else $error("read one result not armed");

	// Register access framing.
	a_reg_framing: assert property (idle_byte &&
		(rbyte[7:5] == ascd_pkg::OP_REG_READ ||
		rbyte[7:5] == ascd_pkg::OP_REG_WRITE) |=>
		q.state == ascd_pkg::ST_COUNT && q.addr == $past(rbyte[4:0]))
		else $error("register command not framed");
	a_write_stores: assert property (new_byte &&
		q.state == ascd_pkg::ST_WRITE &&
		q.addr != ascd_pkg::REG_ID |=>
		q.regs[$past(q.addr)] == $past(rbyte))
		else $error("register write data not stored");
	a_id_locked: assert property (
		q.regs[ascd_pkg::REG_ID] == ascd_pkg::ID_VALUE)
		else $error("identity register changed");
	a_read_load: assert property (new_byte &&
		q.state == ascd_pkg::ST_COUNT && !q.is_write |=>
		q.tx_word[31:24] == $past(q.regs[q.addr]))
		else $error("register read data not loaded");

	// Synchronisation and calibration.
	a_resync_refused: assert property (idle_byte &&
		!q.sync_pin[1] && rbyte[7:1] == ascd_pkg::OP_RESYNC |=>
		!q.conv.restart)
		else $error("resync taken with sync pin low");
	a_offset_start: assert property (idle_byte &&
		rbyte == ascd_pkg::OP_OFFSET_CAL |=>
		q.cal == ascd_pkg::CAL_OFFSET && q.cal_cnt == 5'h0)
		else $error("offset calibration not started");
	a_gain_start: assert property (idle_byte &&
		rbyte == ascd_pkg::OP_GAIN_CAL |=>
		q.cal == ascd_pkg::CAL_GAIN && q.cal_cnt == 5'h0)
		else $error("gain calibration not started");
	a_bypass_offset: assert property (
		q.conv.full_scale_bypass == (q.cal == ascd_pkg::CAL_OFFSET))
		else $error("full-scale bypass outside offset calibration");
	a_gain_store: assert property (conv_i.done && q.conv.run &&
		q.blank == 6'h0 && q.cal == ascd_pkg::CAL_GAIN &&
		q.cal_cnt == ascd_pkg::CAL_READINGS - 5'h1 |=>
		q.regs[ascd_pkg::REG_GAIN_LO +: 3] == $past(conv_i.gain_estimate)
		&& q.cal == ascd_pkg::CAL_NONE)
		else $error("gain correction not stored");

	c_standby: cover property (idle_byte &&
		rbyte[7:1] == ascd_pkg::OP_STANDBY);

	c_reg_write: cover property (new_byte && q.state == ascd_pkg::ST_WRITE);
	c_reg_read: cover property (new_byte && q.state == ascd_pkg::ST_READ);
	c_cal_done: cover property (q.cal != ascd_pkg::CAL_NONE ##1
		q.cal == ascd_pkg::CAL_NONE);
	c_ready_low: cover property ($fell(q.ready_n));

endmodule : ascd_decoder

// file: tb/ascd_host_model.sv
/*
 * Host model that masters the serial link of the command decoder.
 * Assumes the decoder samples din on rising sclk and drives dout on falling.
 */
module ascd_host_model (
	output logic sclk_o,
	output logic din_o,
	output logic sync_pin_o,
	input wire logic dout_i
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk_o = 1'b0;
		din_o = 1'b0;
		sync_pin_o = 1'b1;
	end

	task automatic set_sync(input logic level);
		sync_pin_o = level;
	endtask : set_sync

	// The clock stands low between bytes; the odd start offset keeps the
	// 80 ns link clock clear of the master clock edges.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		#13;
		for (int i = 7; i >= 0; i--) begin
			din_o = tx[i];
			#20 sclk_o = 1'b1;
			#40 sclk_o = 1'b0;
			#20 rx[i] = dout_i;
		end
		din_o = ~din_o;
		#1000;
	endtask : xfer
endmodule : ascd_host_model

// file: tb/tb_adc_serial_command_decoder.sv
/*
 * Self-checking bench of the serial command decoder with a host model.
 * Assumes the bench stands in for the conversion engine on conv_i.
 */
module tb_adc_serial_command_decoder;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_i;
	logic rst_b_i;
	logic sclk;
	logic din;
	logic sync_pin;
	logic dout;
	logic ready_n;
	ascd_pkg::ascd_conv_in_s conv;
	ascd_pkg::ascd_conv_out_s conv_o;
	ascd_pkg::ascd_regs_t regs;
	int mismatches;
	int n_checks;
	int cycles;
	int restarts;
	int n;
	logic [7:0] rx;
	logic [31:0] word;
	logic [7:0] defaults [1:10] = '{8'h52, 8'h08, 8'h32, 8'h03, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h40};

	ascd_host_model ascd_host_model_inst (
		.sclk_o(sclk),
		.din_o(din),
		.sync_pin_o(sync_pin),
		.dout_i(dout)
	);

	ascd_decoder ascd_decoder_inst (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.sclk_i(sclk),
		.din_i(din),
		.sync_pin_i(sync_pin),
		.conv_i(conv),
		.dout_o(dout),
		.result_ready_n_o(ready_n),
		.conv_o(conv_o),
		.regs_o(regs)
	);

	////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (conv_o.restart === 1'b1) begin
			restarts <= restarts + 1;
		end
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	task automatic chk_bit(input string what, input logic exp,
		input logic got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic chk_word(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic cmd(input logic [7:0] b);
		ascd_host_model_inst.xfer(b, rx);
	endtask : cmd

	task automatic readings(input int count);
		repeat (count) begin
			@(negedge clk_i);
			conv.done = 1'b1;
			@(negedge clk_i);
			conv.done = 1'b0;
			repeat (8) @(negedge clk_i);
		end
	endtask : readings

	task automatic get_word(input logic [31:0] exp);
		for (int i = 3; i >= 0; i--) begin
			cmd(8'h00);
			word[i*8 +: 8] = rx;
		end
		chk_word("result", exp, word);
	endtask : get_word

	task automatic s_reset();
		for (int a = 1; a <= 10; a++) begin
			chk_word("default", {24'h0, defaults[a]}, {24'h0, regs[a]});
		end
		chk_bit("ready_n", 1'b1, ready_n);
		chk_bit("run", 1'b1, conv_o.run);
	endtask : s_reset

	task automatic s_write();
		n = restarts;
		cmd(8'h11);
		cmd(8'h41);
		cmd(8'h01);
		cmd(8'h51);
		cmd(8'hAA);
		chk_word("reg1", 32'h51, {24'h0, regs[1]});
		chk_word("reg2", 32'hAA, {24'h0, regs[2]});
		chk_bit("corr_en", 1'b0, conv_o.correction_en);
		chk_word("restarts", n + 1, restarts);
		cmd(8'h10);
		conv.data = 32'hC3A5_0F96;
		readings(63);
		chk_bit("ready_n", 1'b1, ready_n);
		readings(1);
		chk_bit("ready_n", 1'b0, ready_n);
		get_word(32'hC3A5_0F96);
	endtask : s_write

	task automatic s_read_stop();
		cmd(8'h11);
		cmd(8'h21);
		cmd(8'h01);
		cmd(8'h00);
		chk_word("rd reg1", 32'h51, {24'h0, rx});
		cmd(8'h00);
		chk_word("rd reg2", 32'hAA, {24'h0, rx});
		conv.data = 32'h5A69_96A5;
		readings(1);
		chk_bit("ready_n", 1'b1, ready_n);
		cmd(8'h12);
		readings(1);
		chk_bit("ready_n", 1'b0, ready_n);
		get_word(32'h5A69_96A5);
	endtask : s_read_stop

	task automatic s_power_sync();
		cmd(8'h03);
		chk_bit("run", 1'b0, conv_o.run);
		chk_word("reg2", 32'hAA, {24'h0, regs[2]});
		cmd(8'h01);
		chk_bit("run", 1'b1, conv_o.run);
		n = restarts;
		cmd(8'h00);
		chk_bit("run", 1'b1, conv_o.run);
		chk_word("restarts", n, restarts);
		n = restarts;
		cmd(8'h05);
		chk_word("restarts", n + 1, restarts);
		ascd_host_model_inst.set_sync(1'b0);
		cmd(8'h04);
		chk_word("restarts", n + 1, restarts);
		ascd_host_model_inst.set_sync(1'b1);
		cmd(8'h07);
		chk_word("reg2", 32'h08, {24'h0, regs[2]});
		chk_word("restarts", n + 2, restarts);
		chk_bit("corr_en", 1'b1, conv_o.correction_en);
	endtask : s_power_sync

	// Both calibrations run through the full host sequence, sync held high.
	task automatic s_cal(input logic [7:0] op, input int a,
		input logic [23:0] exp);
		conv.data = 32'h0012_3456;
		conv.gain_estimate = 24'h3C_B2D1;
		cmd(8'h11);
		cmd(8'h05);
		cmd(8'h10);
		readings(64);
		chk_bit("ready_n", 1'b0, ready_n);
		cmd(8'h11);
		cmd(op);
		cmd(8'h10);
		chk_bit("bypass", op == 8'h60, conv_o.full_scale_bypass);
		readings(17);
		chk_bit("ready_n", 1'b0, ready_n);
		chk_word("cal", {8'h0, exp}, {8'h0, regs[a+2], regs[a+1], regs[a]});
	endtask : s_cal

	initial begin
		rst_b_i = 1'b0;
		conv = '0;
		cycles = 0;
		restarts = 0;
		mismatches = 0;
		n_checks = 0;
		repeat (3) @(negedge clk_i);
		rst_b_i = 1'b1;
		s_reset();
		s_write();
		s_read_stop();
		s_power_sync();
		s_cal(8'h60, 5, 24'h00_1234);
		s_cal(8'h61, 8, 24'h3C_B2D1);
		close_out();
	end
endmodule : tb_adc_serial_command_decoder
